/* hdl/hbc_regs.v */
// Host buffer control register bank: scratch word, keyed soft reset, buffer state flags and
// the direct window setup. Assumes a command-code port: the processor presents a command on
// cmd_valid, then one 16-bit data phase per data_valid (two for the window setup).
`timescale 1ns/1ps
`include "hbc_consts.vh"

module hbc_regs (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Processor command port
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire data_valid,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    output reg rd_valid,
    // Transfer engine status
    input wire half_toggle,
    input wire iso_a_done_set,
    input wire iso_b_done_set,
    input wire iso_a_busy,
    input wire iso_b_busy,
    // Transfer engine controls
    output wire async_list_run,
    output wire periodic_list_run,
    output wire iso_a_filled,
    output wire iso_b_filled,
    output wire [14:0] window_base,
    output wire [15:0] window_byte_total,
    output wire soft_reset_pulse
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [7:0] cmd_q;
    reg phase_q;
    reg [15:0] scratch_word_q;
    reg [3:0] run_bits_q;
    reg clear_half_toggle_q;
    reg paired_desc_half_q;
    reg iso_a_consumed_q;
    reg iso_b_consumed_q;
    reg iso_a_in_use_q;
    reg iso_b_in_use_q;
    reg [31:0] direct_window_setup_q;
    reg soft_reset_q;
    wire any_reset;
    wire wr_phase;
    wire [15:0] status_word;
    wire scratch_wr;
    wire status_wr;
    wire window_lo_wr;
    wire window_hi_wr;
    wire half_clear;
    reg [15:0] rd_word_d;
    reg rd_hit_d;

    // A soft reset acts one cycle after the key write, so the write itself completes cleanly.
    assign any_reset = srst | soft_reset_q;
    assign wr_phase = data_valid & ~cmd_valid;
    assign soft_reset_pulse = soft_reset_q;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function wr_hit;
        input [7:0] cur;
        input [7:0] code;
        begin
            wr_hit = (cur == code);
        end
    endfunction

    // Read codes the bank answers; the key register and unknown codes get no answer at all.
    function rd_known;
        input [7:0] code;
        begin
            rd_known = (code == `HBC_CMD_SCRATCH_RD) | (code == `HBC_CMD_BSTAT_RD)
                       | (code == `HBC_CMD_WINDOW_RD);
        end
    endfunction

    function [15:0] window_half;
        input [31:0] word;
        input upper;
        begin
            window_half = upper ? word[31:16] : word[15:0];
        end
    endfunction

    // A done event wins over the rearm, so an event is never lost to a cleared filled bit in that cycle.
    function done_next;
        input cur;
        input fire;
        input filled;
        begin
            if (fire) begin
                done_next = 1'b1;
            end else if (!filled) begin
                done_next = 1'b0;
            end else begin
                done_next = cur;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Phase decode
    // ----------------------------------------------------------------
    // Every register write needs a data phase under the stored command; a command code on
    // its own never changes a register.
    assign scratch_wr = wr_phase & wr_hit(cmd_q, `HBC_CMD_SCRATCH_WR);
    assign status_wr = wr_phase & wr_hit(cmd_q, `HBC_CMD_BSTAT_WR);
    assign window_lo_wr = wr_phase & wr_hit(cmd_q, `HBC_CMD_WINDOW_WR) & ~phase_q;
    assign window_hi_wr = wr_phase & wr_hit(cmd_q, `HBC_CMD_WINDOW_WR) & phase_q;
    // Only a 0 to 1 step of stored bit 4 clears the half flag, and only while the
    // asynchronous list is stopped, so a running list never loses its place.
    assign half_clear = status_wr & wr_data[`HBC_BIT_CLEAR_TOGGLE] & ~clear_half_toggle_q
                        & ~run_bits_q[`HBC_BIT_ASYNC_RUN];

    // ----------------------------------------------------------------
    // Command tracking
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            cmd_q <= 8'h00;
            phase_q <= 1'b0;
        end else if (cmd_valid) begin
            cmd_q <= cmd_code;
            phase_q <= 1'b0;
        end else if (data_valid) begin
            // Further phases repeat the stored command; the phase bit alternates, so a run of
            // window phases walks lower half, upper half, lower half again.
            phase_q <= ~phase_q;
        end
    end

    // ----------------------------------------------------------------
    // Soft reset
    // ----------------------------------------------------------------
    // The key must match in all sixteen bits; any other value under the key code is dropped.
    always @(posedge clk) begin
        if (srst) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= wr_phase & wr_hit(cmd_q, `HBC_CMD_SRESET_WR)
                            & (wr_data == `HBC_SRESET_KEY);
        end
    end

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (any_reset) begin
            scratch_word_q <= `HBC_SCRATCH_RST;
        end else if (scratch_wr) begin
            scratch_word_q <= wr_data;
        end
    end

    always @(posedge clk) begin
        if (any_reset) begin
            run_bits_q <= 4'h0;
            clear_half_toggle_q <= 1'b0;
        end else if (status_wr) begin
            run_bits_q <= wr_data[3:0];
            clear_half_toggle_q <= wr_data[`HBC_BIT_CLEAR_TOGGLE];
        end
    end

    always @(posedge clk) begin
        if (any_reset) begin
            direct_window_setup_q <= `HBC_WINDOW_RST;
        end else begin
            if (window_lo_wr) begin
                // Bit 15 is reserved and never stored.
                direct_window_setup_q[14:0] <= wr_data[14:0];
            end
            if (window_hi_wr) begin
                direct_window_setup_q[31:16] <= wr_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // Hardware-set status
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (any_reset) begin
            iso_a_in_use_q <= 1'b0;
            iso_b_in_use_q <= 1'b0;
        end else begin
            // The busy levels are registered, so the status word shows them one cycle late.
            iso_a_in_use_q <= iso_a_busy;
            iso_b_in_use_q <= iso_b_busy;
        end
    end

    // Done flags clear while their filled bit is 0 and no done event arrives: clearing a buffer's filled bit rearms its flag.
    always @(posedge clk) begin
        if (any_reset) begin
            iso_a_consumed_q <= 1'b0;
        end else begin
            iso_a_consumed_q <= done_next(iso_a_consumed_q, iso_a_done_set,
                                          run_bits_q[`HBC_BIT_ISO_A_FILLED]);
        end
    end

    always @(posedge clk) begin
        if (any_reset) begin
            iso_b_consumed_q <= 1'b0;
        end else begin
            iso_b_consumed_q <= done_next(iso_b_consumed_q, iso_b_done_set,
                                          run_bits_q[`HBC_BIT_ISO_B_FILLED]);
        end
    end

    // A clear beats a toggle in the same cycle, so software always restarts on the first half.
    always @(posedge clk) begin
        if (any_reset) begin
            paired_desc_half_q <= 1'b0;
        end else if (half_clear) begin
            paired_desc_half_q <= 1'b0;
        end else if (half_toggle) begin
            paired_desc_half_q <= ~paired_desc_half_q;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    assign status_word = {5'h00, paired_desc_half_q, iso_b_consumed_q, iso_a_consumed_q,
                          1'b0, iso_b_in_use_q, iso_a_in_use_q, clear_half_toggle_q,
                          run_bits_q};

    // Reads are decoded here and registered once, so rd_data and rd_valid come from flip-flops.
    always @* begin
        rd_word_d = 16'h0000;
        rd_hit_d = rd_known(cmd_q);
        case (cmd_q)
            `HBC_CMD_SCRATCH_RD: begin
                rd_word_d = scratch_word_q;
            end
            `HBC_CMD_BSTAT_RD: begin
                rd_word_d = status_word;
            end
            `HBC_CMD_WINDOW_RD: begin
                rd_word_d = window_half(direct_window_setup_q, phase_q);
            end
            default: begin
                rd_word_d = 16'h0000;
            end
        endcase
    end

    always @(posedge clk) begin
        if (any_reset) begin
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= wr_phase & rd_hit_d;
            if (wr_phase & rd_hit_d) begin
                rd_data <= rd_word_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Engine controls
    // ----------------------------------------------------------------
    // The run and filled levels come straight from the stored bits, so the engines see a
    // status write in the cycle after its data phase.
    assign async_list_run = run_bits_q[`HBC_BIT_ASYNC_RUN];
    assign periodic_list_run = run_bits_q[`HBC_BIT_PERIODIC_RUN];
    assign iso_b_filled = run_bits_q[`HBC_BIT_ISO_B_FILLED];
    assign iso_a_filled = run_bits_q[`HBC_BIT_ISO_A_FILLED];
    // The data port engine reads these as its start point and length.
    assign window_base = direct_window_setup_q[`HBC_WIN_BASE_MSB:0];
    assign window_byte_total = direct_window_setup_q[31:`HBC_WIN_COUNT_LSB];

endmodule // hbc_regs

/* hdl/hbc_consts.vh */
// Command codes, field positions, reset values and keys for the host buffer control registers.
// Assumes it is included by bare name from the design file; definitions only.
`ifndef HBC_CONSTS_VH
`define HBC_CONSTS_VH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define HBC_CMD_SCRATCH_RD 8'h28
`define HBC_CMD_SCRATCH_WR 8'ha8
`define HBC_CMD_SRESET_WR 8'ha9
`define HBC_CMD_BSTAT_RD 8'h2c
`define HBC_CMD_BSTAT_WR 8'hac
`define HBC_CMD_WINDOW_RD 8'h32
`define HBC_CMD_WINDOW_WR 8'hb2

// ----------------------------------------------------------------
// Buffer status field positions
// ----------------------------------------------------------------
`define HBC_BIT_ISO_A_FILLED 0
`define HBC_BIT_ISO_B_FILLED 1
`define HBC_BIT_PERIODIC_RUN 2
`define HBC_BIT_ASYNC_RUN 3
`define HBC_BIT_CLEAR_TOGGLE 4
`define HBC_BIT_ISO_A_IN_USE 5
`define HBC_BIT_ISO_B_IN_USE 6
`define HBC_BIT_ISO_A_DONE 8
`define HBC_BIT_ISO_B_DONE 9
`define HBC_BIT_DESC_HALF 10

// ----------------------------------------------------------------
// Window setup fields and reset values
// ----------------------------------------------------------------
`define HBC_WIN_BASE_MSB 14
`define HBC_WIN_COUNT_LSB 16
`define HBC_SCRATCH_RST 16'h0000
`define HBC_WINDOW_RST 32'h0000_0000
`define HBC_SRESET_KEY 16'h00f6

`endif

/* sim/hbc_regs_sva.sv */
// Checker for the command port and control outputs of hbc_regs.
// Assumes srst is synchronous and active high and the host keeps to the command protocol.
`timescale 1ns/1ps
module hbc_regs_sva (
    // Clock and reset
    input clk,
    input srst,
    // Command port
    input cmd_valid,
    input [7:0] cmd_code,
    input data_valid,
    input [15:0] wr_data,
    input rd_valid,
    // Engine controls
    input async_list_run,
    input periodic_list_run,
    input iso_a_filled,
    input iso_b_filled,
    input [14:0] window_base,
    input [15:0] window_byte_total,
    input soft_reset_pulse
);
    reg [7:0] cmd_q;
    reg hi_q;
    wire ph = data_valid && !cmd_valid;
    wire rd_cmd = cmd_q == 8'h28 || cmd_q == 8'h2c || cmd_q == 8'h32;
    wire [3:0] ctl = {async_list_run, periodic_list_run, iso_b_filled, iso_a_filled};
    wire [30:0] win = {window_byte_total, window_base};
    always @(posedge clk) begin
        if (srst || soft_reset_pulse || cmd_valid) begin
            cmd_q <= (srst || soft_reset_pulse) ? 8'h00 : cmd_code;
            hi_q <= 1'b0;
        end else if (ph) begin
            hi_q <= ~hi_q;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_read_answer: assert property (rd_valid == $past(ph && rd_cmd))
        else $error("Read answer out of place.");
    a_key_pulse: assert property (soft_reset_pulse == $past(ph && cmd_q == 8'ha9 && wr_data == 16'h00f6))
        else $error("Soft reset pulse mismatch.");
    a_soft_clears: assert property (soft_reset_pulse |=> ctl == 4'h0 && win == 31'h0)
        else $error("Soft reset left state.");
    a_status_write: assert property (ph && cmd_q == 8'hac |=> ctl == $past(wr_data[3:0]))
        else $error("Control bits wrong.");
    a_window_lo: assert property (ph && cmd_q == 8'hb2 && !hi_q |=> window_base == $past(wr_data[14:0]))
        else $error("Window base wrong.");
    a_window_hi: assert property (ph && cmd_q == 8'hb2 && hi_q |=> window_byte_total == $past(wr_data))
        else $error("Window count wrong.");
    a_ctrl_hold: assert property (!(ph && cmd_q == 8'hac) && !soft_reset_pulse |=> $stable(ctl))
        else $error("Control bits moved.");
    a_window_hold: assert property (!(ph && cmd_q == 8'hb2) && !soft_reset_pulse |=> $stable(win))
        else $error("Window setup moved.");
    c_soft: cover property (soft_reset_pulse);
    c_win_hi: cover property (ph && cmd_q == 8'hb2 && hi_q);
    c_read: cover property (rd_valid);
endmodule // hbc_regs_sva
bind hbc_regs hbc_regs_sva hbc_regs_sva_inst (.clk, .srst, .cmd_valid, .cmd_code, .data_valid,
    .wr_data, .rd_valid, .async_list_run, .periodic_list_run, .iso_a_filled, .iso_b_filled,
    .window_base, .window_byte_total, .soft_reset_pulse);

/* sim/hbc_host_model.sv */
// Host processor model: issues command codes and 16-bit data phases.
// Assumes the answer to a read phase stands in the cycle after that phase.
`timescale 1ns/1ps
module hbc_host_model (
    // Clock and answer
    input clk,
    input [15:0] rd_data,
    input rd_valid,
    // Command port
    output reg cmd_valid,
    output reg [7:0] cmd_code,
    output reg data_valid,
    output reg [15:0] wr_data
);
    integer i;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        data_valid = 1'b0;
        wr_data = 16'h0000;
    end
    // Idle lines carry inverted data so a stale value is never mistaken for a fresh one.
    task xfer(input [7:0] c, input [31:0] d, input integer n, output [31:0] q);
        begin
            q = 32'h0000_0000;
            @(negedge clk);
            cmd_valid = 1'b1;
            cmd_code = c;
            for (i = 0; i <= n; i = i + 1) begin
                @(negedge clk);
                if (i > 0)
                    q[16*(i-1) +: 16] = rd_valid ? rd_data : 16'hxxxx;
                cmd_valid = 1'b0;
                cmd_code = ~c;
                data_valid = i < n;
                wr_data = (i < n) ? d[16*(i%2) +: 16] : ~wr_data;
            end
        end
    endtask
endmodule // hbc_host_model

/* sim/host_buffer_control_regs_tb_top.sv */
// Testbench for hbc_regs: register tests through the host model, engine flags driven here.
// Assumes the checker is bound to the design.
`timescale 1ns/1ps
module host_buffer_control_regs_tb_top;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [4:0] eng = 5'h00;
    reg [31:0] q;
    integer n_errors = 0, checked = 0;
    wire cmd_valid, data_valid, rd_valid, async_list_run, periodic_list_run;
    wire iso_a_filled, iso_b_filled, soft_reset_pulse;
    wire [7:0] cmd_code;
    wire [15:0] wr_data, rd_data, window_byte_total;
    wire [14:0] window_base;
    always #50 clk = ~clk;
    hbc_host_model hbc_host_model_inst (.clk, .rd_data, .rd_valid, .cmd_valid, .cmd_code,
        .data_valid, .wr_data);
    hbc_regs hbc_regs_inst (.clk, .srst, .cmd_valid, .cmd_code, .data_valid, .wr_data,
        .rd_data, .rd_valid, .half_toggle(eng[0]), .iso_a_done_set(eng[1]),
        .iso_b_done_set(eng[2]), .iso_a_busy(eng[3]), .iso_b_busy(eng[4]), .async_list_run,
        .periodic_list_run, .iso_a_filled, .iso_b_filled, .window_base, .window_byte_total,
        .soft_reset_pulse);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task rd(input [7:0] c, input [31:0] exp, input integer n);
        begin
            hbc_host_model_inst.xfer(c, 32'h0, n, q);
            chk(q, exp);
        end
    endtask
    task wr(input [7:0] c, input [31:0] d, input integer n);
        hbc_host_model_inst.xfer(c, d, n, q);
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", checked, n_errors);
            if (n_errors == 0 && checked > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_errors = n_errors + 1;
        test_done;
    end
    initial begin
        repeat (4) @(negedge clk);
        srst = 1'b0;
        rd(8'h28, 32'h0, 1);
        rd(8'h2c, 32'h0, 1);
        rd(8'h32, 32'h0, 2);
        wr(8'ha8, 32'ha5c3, 1);
        rd(8'h28, 32'ha5c3, 1);
        wr(8'hb2, 32'hbeef_ffff, 2);
        chk({window_byte_total, 1'b0, window_base}, 32'hbeef_7fff);
        rd(8'h32, 32'hbeef_7fff, 2);
        $display("test scratch and window done");
        wr(8'hac, 32'hffff, 1);
        chk({async_list_run, periodic_list_run, iso_b_filled, iso_a_filled}, 4'hf);
        @(negedge clk) eng = 5'h1f;
        @(negedge clk) eng = 5'h18;
        rd(8'h2c, 32'h077f, 1);
        @(negedge clk) eng = 5'h00;
        wr(8'hac, 32'h000f, 1);
        wr(8'hac, 32'h001f, 1);
        rd(8'h2c, 32'h071f, 1);
        wr(8'hac, 32'h0003, 1);
        wr(8'hac, 32'h0013, 1);
        rd(8'h2c, 32'h0313, 1);
        wr(8'hac, 32'h0010, 1);
        rd(8'h2c, 32'h0010, 1);
        $display("test buffer status done");
        wr(8'ha9, 32'h0055, 1);
        rd(8'h28, 32'ha5c3, 1);
        wr(8'ha9, 32'h00f6, 1);
        rd(8'ha9, 32'h0000_xxxx, 1);
        rd(8'h28, 32'h0, 1);
        rd(8'h2c, 32'h0, 1);
        rd(8'h32, 32'h0, 2);
        $display("test soft reset done");
        test_done;
    end
endmodule // host_buffer_control_regs_tb_top
